// *** igcd_top.v ***
// i2c slave general-call command decoder with config load
`include "igcd_defines.vh"

// How it works
// - command 06h soft resets, empties buffers
// - command 0eh flushes transmit and receive buffers
// - after 0ch, next read returns data count
// - after 16h, next read returns usb state
// - usb state codes 00h to 03h
// - identification is three bytes, 12/9/3 bits
// - continued acks wrap identification bytes
// - power-on or usb reset loads configuration
// - power enable low configured, high suspended
// - stay-awake low blocks suspend when unplugged
// - optional pull-down of lines whenever usb state is not configured
// - two pins high-z, one shows suspend
// - data count saturates at ffh
// - nack read address when transmit empty and no reply pending
module igcd_top (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output wire        sda_oe_n,
  input  wire        usb_reset,
  input  wire [1:0]  usb_state,
  input  wire        usb_attached,
  input  wire        bus_power_detect,
  input  wire        stay_awake_n,
  input  wire [9:0]  tx_count,
  output reg         soft_reset,
  output reg         flush_tx,
  output reg         flush_rx,
  output reg         rd_pop,
  input  wire        cfg_wr,
  input  wire [2:0]  cfg_waddr,
  input  wire [7:0]  cfg_wdata,
  output reg  [6:0]  slave_addr,
  output reg         suspend_pd_en,
  output wire        power_enable_n,
  output wire        suspend_allow,
  output wire        pull_down_lines,
  output wire [2:0]  configurable_io_pins,
  output wire [2:0]  configurable_io_oe_n
);
  parameter [11:0] MFR_ID  = 12'h5a5; // arbitrary value
  parameter [8:0]  PART_ID = 9'h0a3;  // arbitrary value
  parameter [2:0]  REV_ID  = 3'h1;    // arbitrary value

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_AACK = 3'h2;
  localparam ST_WR   = 3'h3;
  localparam ST_WACK = 3'h4;
  localparam ST_RD   = 3'h5;
  localparam ST_RACK = 3'h6;
  localparam ST_SKIP = 3'h7;

  wire scl_s;
  wire sda_s;
  wire awake_n_s;
  wire vbus_s;
  wire [7:0] cfg_rdata;
  igcd_sync u_scl (.mclk(mclk), .sys_rst(sys_rst), .din(scl_i), .dout(scl_s));
  igcd_sync u_sda (.mclk(mclk), .sys_rst(sys_rst), .din(sda_i), .dout(sda_s));
  // the stay-awake and bus power pins are asynchronous too
  igcd_sync u_awake (.mclk(mclk), .sys_rst(sys_rst), .din(stay_awake_n), .dout(awake_n_s));
  igcd_sync u_vbus (.mclk(mclk), .sys_rst(sys_rst), .din(bus_power_detect), .dout(vbus_s));

  reg        scl_q, sda_q;
  reg  [2:0] st_q;
  reg  [3:0] bit_q;
  reg  [7:0] sh_q;
  reg  [7:0] tx_q;
  reg        rw_q;
  reg        gc_q;
  reg        id_q;
  reg        byte1_q;
  reg  [1:0] pend_q;
  reg  [1:0] id_idx_q;
  reg        id_arm_q;
  reg        cfg_busy_q;
  reg  [1:0] cfg_step_q;
  reg  [2:0] cfg_raddr_q;
  reg        usb_rst_q;
  wire       cfg_ld;
  wire       scl_rise = scl_s & ~scl_q;
  wire       scl_fall = ~scl_s & scl_q;
  wire       start_c  = scl_s & scl_q & sda_q & ~sda_s;
  wire       stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  wire [7:0] avail    = (tx_count > 10'd255) ? `IGCD_AVAIL_MAX : tx_count[7:0];
  wire [23:0] id_word = {MFR_ID, PART_ID, REV_ID};
  wire [6:0] adr7     = sh_q[7:1];
  reg  [7:0] rd_byte;

  // open-drain pin: enable low while pulling sda low
  assign sda_oe_n = sda_o;

  // byte chosen for the next read answer
  always @* begin
    case (pend_q)
      `IGCD_PEND_AVAIL: rd_byte = avail;
      `IGCD_PEND_USB:   rd_byte = {6'h00, usb_state};
      `IGCD_PEND_ID: begin
        case (id_idx_q)
          2'h0:    rd_byte = id_word[23:16];
          2'h1:    rd_byte = id_word[15:8];
          default: rd_byte = id_word[7:0];
        endcase
      end
      default:          rd_byte = 8'h00;
    endcase
  end

  // configuration load after reset or usb reset; user writes only reach the memory and apply at the next load
  assign cfg_ld = sys_rst | (usb_reset & ~usb_rst_q);
  always @(posedge mclk) begin
    if (sys_rst) begin
      usb_rst_q     <= 1'b0;
      cfg_busy_q    <= 1'b1;
      cfg_step_q    <= 2'h0;
      cfg_raddr_q   <= `IGCD_CFG_ADDR_IDX;
      slave_addr    <= `IGCD_DEF_SLAVE_ADDR;
      suspend_pd_en <= `IGCD_DEF_PD_EN;
    end else begin
      usb_rst_q <= usb_reset;
      if (cfg_ld) begin
        cfg_busy_q  <= 1'b1;
        cfg_step_q  <= 2'h0;
        cfg_raddr_q <= `IGCD_CFG_ADDR_IDX;
      end else if (cfg_busy_q) begin
        // one cycle to present address, then capture registered data
        cfg_step_q  <= cfg_step_q + 2'h1;
        cfg_raddr_q <= `IGCD_CFG_PD_IDX;
        if (cfg_step_q == 2'h1) begin
          if (cfg_rdata[7]) begin
            slave_addr <= cfg_rdata[6:0];
          end
        end
        if (cfg_step_q == 2'h2) begin
          if (cfg_rdata[7]) begin
            suspend_pd_en <= cfg_rdata[0];
          end
          cfg_busy_q <= 1'b0;
        end
      end
    end
  end

  // bit 7 of a stored word marks it valid; blank memory keeps defaults
  igcd_cfg_mem u_cfg (
    .mclk  (mclk),
    .we    (cfg_wr),
    .waddr (cfg_waddr),
    .wdata (cfg_wdata),
    .raddr (cfg_raddr_q),
    .rdata (cfg_rdata)
  );

  // i2c slave state machine
  always @(posedge mclk) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      gc_q <= 1'b0;
      id_q <= 1'b0;
      byte1_q <= 1'b0;
      pend_q <= `IGCD_PEND_NONE;
      id_idx_q <= 2'h0;
      id_arm_q <= 1'b0;
      sda_o <= 1'b1;
      soft_reset <= 1'b0;
      flush_tx <= 1'b0;
      flush_rx <= 1'b0;
      rd_pop <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      soft_reset <= 1'b0;
      flush_tx <= 1'b0;
      flush_rx <= 1'b0;
      rd_pop <= 1'b0;
      if (start_c) begin
        st_q <= ST_ADDR;
        bit_q <= 4'h0;
        sda_o <= 1'b1;
      end else if (stop_c) begin
        st_q <= ST_IDLE;
        sda_o <= 1'b1;
        id_arm_q <= 1'b0;
      end else begin
        case (st_q)
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              bit_q <= bit_q + 4'h1;
            end
            if (scl_fall && bit_q == 4'h8) begin
              bit_q <= 4'h0;
              if (st_q == ST_ADDR) begin
                rw_q <= sh_q[0];
                gc_q <= (adr7 == `IGCD_GC_ADDR) & ~sh_q[0];
                id_q <= adr7 == `IGCD_ID_ADDR;
                byte1_q <= 1'b1;
                if (adr7 == `IGCD_GC_ADDR && !sh_q[0]) begin
                  sda_o <= 1'b0;
                  st_q <= ST_AACK;
                end else if (adr7 == `IGCD_ID_ADDR) begin
                  sda_o <= 1'b0;
                  st_q <= ST_AACK;
                  if (sh_q[0] && id_arm_q) begin
                    pend_q <= `IGCD_PEND_ID;
                    id_idx_q <= 2'h0;
                  end
                end else if (adr7 == slave_addr && !sh_q[0]) begin
                  sda_o <= 1'b0;
                  st_q <= ST_AACK;
                end else if (adr7 == slave_addr && (pend_q != `IGCD_PEND_NONE || tx_count != 10'd0)) begin
                  sda_o <= 1'b0;
                  st_q <= ST_AACK;
                end else begin
                  st_q <= ST_SKIP;
                end
              end else begin
                // data byte written to us
                sda_o <= 1'b0;
                st_q <= ST_WACK;
                byte1_q <= 1'b0;
                if (gc_q && byte1_q) begin
                  case (sh_q)
                    `IGCD_CMD_SOFT_RST: begin
                      soft_reset <= 1'b1;
                      flush_tx <= 1'b1;
                      flush_rx <= 1'b1;
                      pend_q <= `IGCD_PEND_NONE;
                    end
                    `IGCD_CMD_FLUSH: begin
                      flush_tx <= 1'b1;
                      flush_rx <= 1'b1;
                    end
                    `IGCD_CMD_AVAIL: pend_q <= `IGCD_PEND_AVAIL;
                    `IGCD_CMD_USB_STATE: pend_q <= `IGCD_PEND_USB;
                    default: pend_q <= pend_q;
                  endcase
                end else if (id_q && byte1_q) begin
                  // slave address byte after 7ch write; direction ignored
                  id_arm_q <= sh_q[7:1] == slave_addr;
                end
              end
            end
          end
          ST_AACK, ST_WACK: begin
            if (scl_fall) begin
              if (rw_q && st_q == ST_AACK) begin
                tx_q <= rd_byte;
                sda_o <= rd_byte[7];
                bit_q <= 4'h1;
                st_q <= ST_RD;
                // an identification read never takes a byte from the buffer
                if (pend_q == `IGCD_PEND_NONE && !id_q) begin
                  rd_pop <= 1'b1;
                end
              end else begin
                sda_o <= 1'b1;
                st_q <= ST_WR;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_q == 4'h8) begin
                sda_o <= 1'b1;
                st_q <= ST_RACK;
              end else begin
                sda_o <= tx_q[3'h7 - bit_q[2:0]];
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                st_q <= ST_SKIP; // master nack ends read
                // identification too, else later plain reads would return id bytes
                pend_q <= `IGCD_PEND_NONE;
              end else begin
                if (pend_q == `IGCD_PEND_ID) begin
                  id_idx_q <= (id_idx_q == 2'h2) ? 2'h0 : id_idx_q + 2'h1;
                end else if (pend_q != `IGCD_PEND_NONE) begin
                  pend_q <= `IGCD_PEND_NONE;
                end
                st_q <= ST_AACK;
              end
            end
          end
          default: sda_o <= 1'b1; // idle or skipping: release sda
        endcase
      end
    end
  end

  // suspend related pin functions
  wire suspended = ({6'h00, usb_state} == `IGCD_USB_SUSPENDED);
  assign power_enable_n  = ~({6'h00, usb_state} == `IGCD_USB_CONFIGURED);
  assign suspend_allow   = ~(~awake_n_s & ~usb_attached & ~vbus_s);
  assign pull_down_lines = suspend_pd_en & power_enable_n;
  // pin 0 shows sleep (active low), pins 1 and 2 left undriven
  assign configurable_io_pins = {2'b00, ~suspended};
  assign configurable_io_oe_n = 3'b110;
endmodule // igcd_top

// *** igcd_defines.vh ***
// constants for the i2c general-call command decoder
`ifndef IGCD_DEFINES_VH
`define IGCD_DEFINES_VH
`define IGCD_GC_ADDR        7'h00
`define IGCD_DEF_SLAVE_ADDR 7'h22
`define IGCD_ID_ADDR        7'h7c
`define IGCD_CMD_SOFT_RST   8'h06
`define IGCD_CMD_FLUSH      8'h0e
`define IGCD_CMD_AVAIL      8'h0c
`define IGCD_CMD_USB_STATE  8'h16
`define IGCD_USB_SUSPENDED  8'h00
`define IGCD_USB_DEFAULT    8'h01
`define IGCD_USB_ADDRESSED  8'h02
`define IGCD_USB_CONFIGURED 8'h03
`define IGCD_AVAIL_MAX      8'hff
`define IGCD_PEND_NONE      2'h0
`define IGCD_PEND_AVAIL     2'h1
`define IGCD_PEND_USB       2'h2
`define IGCD_PEND_ID        2'h3
`define IGCD_CFG_WORDS      4'h8
`define IGCD_CFG_ADDR_IDX   3'h0
`define IGCD_CFG_PD_IDX     3'h1
`define IGCD_DEF_PD_EN      1'b0
`endif

// *** igcd_sync.v ***
// two-flop synchroniser for pin inputs
module igcd_sync (
  input  wire mclk,
  input  wire sys_rst,
  input  wire din,
  output wire dout
);
  reg meta_q;
  reg sync_q;
  // first flop is read only by the second
  always @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end
  assign dout = sync_q;
endmodule // igcd_sync

// *** igcd_cfg_mem.v ***
// small configuration memory with registered read data
module igcd_cfg_mem (
  input  wire       mclk,
  input  wire       we,
  input  wire [2:0] waddr,
  input  wire [7:0] wdata,
  input  wire [2:0] raddr,
  output reg  [7:0] rdata
);
  reg [7:0] mem [0:7];
  // registered read port keeps timing clean
  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // igcd_cfg_mem

// *** igcd_props.sv ***
// assertion checker for the general-call decoder top
module igcd_props (
  input wire       mclk,
  input wire       sys_rst,
  input wire [1:0] usb_state,
  input wire       usb_attached,
  input wire       bus_power_detect,
  input wire       stay_awake_n,
  input wire       soft_reset,
  input wire       flush_tx,
  input wire       flush_rx,
  input wire [6:0] slave_addr,
  input wire       suspend_pd_en,
  input wire       power_enable_n,
  input wire       suspend_allow,
  input wire       pull_down_lines,
  input wire [2:0] configurable_io_pins,
  input wire [2:0] configurable_io_oe_n
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // inputs are held a few cycles so the pin synchronisers settle first
  sequence s_unplugged;
    (!stay_awake_n && !usb_attached && !bus_power_detect) [*4];
  endsequence
  sequence s_configured;
    (usb_state == 2'h3) [*3];
  endsequence
  a_pwr_en_low: assert property (s_configured |-> !power_enable_n)
    else $error("power enable high while configured");
  a_pull_down_lines: assert property (pull_down_lines == (suspend_pd_en && power_enable_n))
    else $error("pull-down mismatch");
  a_pins_default: assert property (configurable_io_oe_n == 3'b110)
    else $error("pin enables wrong");
  a_pin_suspend: assert property ((usb_state == 2'h0) [*3] |-> !configurable_io_pins[0])
    else $error("suspend pin not low");
  a_stay_awake: assert property (s_unplugged |-> !suspend_allow)
    else $error("suspend allowed while kept awake");
  a_soft_pulse: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset longer than a cycle");
  a_flush_both: assert property (flush_tx |-> flush_rx)
    else $error("flush of one buffer only");
  // reset itself is the cause here, so this one stays live through reset
  a_reset_addr: assert property (disable iff (1'b0) sys_rst |=> slave_addr == 7'h22 && !suspend_pd_en)
    else $error("reset defaults wrong");
endmodule // igcd_props

bind igcd_top igcd_props u_props (.mclk, .sys_rst, .usb_state, .usb_attached, .bus_power_detect, .stay_awake_n,
  .soft_reset, .flush_tx, .flush_rx, .slave_addr, .suspend_pd_en, .power_enable_n, .suspend_allow,
  .pull_down_lines, .configurable_io_pins, .configurable_io_oe_n);

// *** igcd_master.sv ***
// i2c master model on the far side of the bus
module igcd_master (
  input  wire  mclk,
  input  wire  sda_in,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus idles released, pulled up
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // eight mclk per bit gives the 320 ns period; sda moves only while scl is low
  task automatic bit_x(input logic b, output logic r);
    w(2);
    sda <= b;
    w(2);
    scl <= 1'b1;
    w(3);
    @(negedge mclk) r = sda_in;
    w(1);
    scl <= 1'b0;
  endtask
  // also serves as repeated start; waits for the slave to let go of an ack first
  task automatic start();
    sda <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(4);
    sda <= 1'b0;
    w(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    sda <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(4);
    sda <= 1'b1;
    w(4);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, nak);
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule // igcd_master

// *** test_i2c_gencall_cmd_decoder.sv ***
// self-checking bench for the general-call command decoder
module test_i2c_gencall_cmd_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] ID = {12'h5a5, 9'h0a3, 3'h1};
  typedef struct packed {
    logic [7:0] cmd;
    logic [9:0] tx;
    logic [1:0] st;
    logic [1:0] sr;
    logic [1:0] fl;
    logic       rd;
    logic [7:0] ex;
  } igcd_row_t;
  igcd_row_t rows [8] = '{'{8'h0c, 10'h12c, 2'h3, 2'h0, 2'h0, 1'b1, 8'hff}, '{8'h0c, 10'h005, 2'h3, 2'h0, 2'h0, 1'b1, 8'h05},
    '{8'h16, 10'h005, 2'h0, 2'h0, 2'h0, 1'b1, 8'h00}, '{8'h16, 10'h005, 2'h1, 2'h0, 2'h0, 1'b1, 8'h01},
    '{8'h16, 10'h005, 2'h2, 2'h0, 2'h0, 1'b1, 8'h02}, '{8'h16, 10'h005, 2'h3, 2'h0, 2'h0, 1'b1, 8'h03},
    '{8'h0e, 10'h005, 2'h3, 2'h0, 2'h1, 1'b0, 8'h00}, '{8'h06, 10'h005, 2'h3, 2'h1, 2'h1, 1'b0, 8'h00}};
  logic       mclk, sys_rst, usb_reset, usb_attached, bus_power_detect, stay_awake_n, cfg_wr, a;
  logic [1:0] usb_state;
  logic [9:0] tx_count;
  logic [2:0] cfg_waddr;
  logic [7:0] cfg_wdata, d;
  wire        scl, sda_m, sda_o, sda_oe_n, soft_reset, flush_tx, flush_rx, suspend_pd_en, pull_down_lines, suspend_allow;
  wire  [6:0] slave_addr;
  wire        rd_pop;
  wire        sda_bus = sda_m & (sda_oe_n | sda_o);
  int         num_errors = 0, num_checks = 0, n_sr = 0, n_fl = 0, b_sr, b_fl;
  int         n_pop = 0, b_pop;
  igcd_master m (.mclk, .sda_in(sda_bus), .scl, .sda(sda_m));
  igcd_top dut (.mclk, .sys_rst, .scl_i(scl), .sda_i(sda_bus), .sda_o, .sda_oe_n, .usb_reset, .usb_state,
    .usb_attached, .bus_power_detect, .stay_awake_n, .tx_count, .soft_reset, .flush_tx, .flush_rx, .rd_pop,
    .cfg_wr, .cfg_waddr, .cfg_wdata, .slave_addr, .suspend_pd_en, .power_enable_n(), .suspend_allow,
    .pull_down_lines, .configurable_io_pins(), .configurable_io_oe_n());
  // pulses last one cycle, so count them rather than poll
  always @(posedge mclk) begin
    n_sr <= n_sr + int'(soft_reset === 1'b1);
    n_fl <= n_fl + int'(flush_tx === 1'b1 && flush_rx === 1'b1);
    n_pop <= n_pop + int'(rd_pop === 1'b1);
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic gc(input logic [7:0] cmd);
    m.start();
    m.wbyte(8'h00, a);
    chk(a, 1'b0);
    m.wbyte(cmd, a);
    m.stop();
  endtask
  task automatic rd(input logic [7:0] ex);
    m.start();
    m.wbyte({7'h22, 1'b1}, a);
    chk(a, 1'b0);
    m.rbyte(1'b1, d);
    m.stop();
    chk(d, ex);
  endtask
  task automatic cfgw(input logic [2:0] ad, input logic [7:0] dt);
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_waddr <= ad;
    cfg_wdata <= dt;
    @(posedge mclk);
    cfg_wr <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // whole run needs well under a millisecond
  initial begin
    #2000000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {sys_rst, usb_attached, bus_power_detect, stay_awake_n} = 4'hf;
    {usb_reset, cfg_wr, cfg_waddr, cfg_wdata} = '0;
    usb_state = 2'h3;
    tx_count = 10'h005;
    // blank config words written under reset so the load finds nothing valid
    cfgw(3'h0, 8'h00);
    cfgw(3'h1, 8'h00);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(slave_addr, 7'h22);
    chk(suspend_pd_en, 1'b0);
    $display("test reset done");
    foreach (rows[k]) begin
      b_sr = n_sr;
      b_fl = n_fl;
      tx_count <= rows[k].tx;
      usb_state <= rows[k].st;
      gc(rows[k].cmd);
      if (rows[k].rd) rd(rows[k].ex);
      repeat (8) @(posedge mclk);
      chk(10'(n_sr - b_sr), rows[k].sr);
      chk(10'(n_fl - b_fl), rows[k].fl);
      $display("row %0d done", k);
    end
    tx_count <= 10'h000;
    m.start();
    m.wbyte({7'h22, 1'b1}, a);
    m.stop();
    chk(a, 1'b1);
    gc(8'h0e);
    gc(8'h0c);
    gc(8'h55);
    rd(8'h00);
    $display("test refuse and stray done");
    tx_count <= 10'h005;
    m.start();
    m.wbyte(8'hf8, a);
    m.wbyte({7'h22, 1'b0}, a);
    m.start();
    m.wbyte(8'hf9, a);
    chk(a, 1'b0);
    for (int i = 0; i < 4; i++) begin
      m.rbyte(i == 3, d);
      chk(d, ID[23 - 8 * (i % 3) -: 8]);
    end
    m.stop();
    // after the nacked id read a plain read must reach the buffer and pop one byte
    b_pop = n_pop;
    rd(8'h00);
    repeat (2) @(posedge mclk);
    chk(10'(n_pop - b_pop), 10'h001);
    $display("test id done");
    {stay_awake_n, usb_attached, bus_power_detect} <= 3'h0;
    repeat (6) @(posedge mclk);
    chk(suspend_allow, 1'b0);
    {stay_awake_n, usb_attached, bus_power_detect} <= 3'h7;
    cfgw(3'h0, 8'hb1);
    cfgw(3'h1, 8'h81);
    usb_reset <= 1'b1;
    repeat (4) @(posedge mclk);
    usb_reset <= 1'b0;
    usb_state <= 2'h0;
    repeat (8) @(posedge mclk);
    chk(slave_addr, 7'h31);
    chk(suspend_pd_en, 1'b1);
    chk(pull_down_lines, 1'b1);
    $display("test awake and config done");
    tally_and_finish();
  end
endmodule // test_i2c_gencall_cmd_decoder
